// file: rtl/adc_seq_regs.svh
// register offsets, field positions, reset values and timing for the sequencer control
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// ==========================================
// register offsets (byte addresses)
`define OFS_ACTIVE 8'h00
`define OFS_RAW_IRQ 8'h04
`define OFS_IRQ_MASK 8'h08
`define OFS_IRQ_CLEAR 8'h0C
`define OFS_OVERFLOW 8'h10
`define OFS_TRIG_SEL 8'h14
`define OFS_UNDERFLOW 8'h18
`define OFS_PRIORITY 8'h20
`define OFS_SW_INIT 8'h28
`define OFS_AVG_CTL 8'h30
`define SEQ_BASE 8'h40
`define SEQ_LIMIT 8'hC0
`define SEQ_BASE_IDX 3'h2
`define SUB_MUX 5'h00
`define SUB_CTL 5'h04
`define SUB_FIFO 5'h08
`define SUB_FSTAT 5'h0C

// ==========================================
// reset values and field layouts
`define PRI_RST 16'h3210
`define PRI_MASK 16'h3333
`define CTL3_RST 32'h0000_0002
`define CTL_DIFF 0
`define CTL_END 1
`define CTL_IE 2
`define CTL_TS 3
`define FST_HEAD 4
`define FST_EMPTY 8
`define FST_FULL 12
`define TRIG_SW 4'h0
`define TRIG_ALWAYS 4'hF
`define CAP_SS0 4'h8
`define CAP_MID 4'h4
`define CAP_SS3 4'h1
`define AVG_MAX 3'h6

// ==========================================
// converter clock derivation
`define MCLK_KHZ 125000
`define CONV_TARGET_KHZ 16667
`define CONV_DIV ((`MCLK_KHZ + `CONV_TARGET_KHZ - 1) / `CONV_TARGET_KHZ)

`endif

// file: rtl/adc_seq_pkg.sv
// types shared by the sequencer control
`default_nettype none
package adc_seq_pkg;

    typedef enum logic [1:0] {
        S_IDLE,
        S_CONV,
        S_STORE
    } seq_state_e;

    // one conversion request towards the analog converter
    typedef struct packed {
        logic valid;
        logic temp;
        logic diff;
        logic [3:0] pos_input;
        logic [3:0] neg_input;
    } conv_req_s;

endpackage
`default_nettype wire

// file: rtl/adc_seq_ctrl.sv
// sample sequencer control: registers, triggers, arbitration, fifos, averaging
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`include "adc_seq_regs.svh"
`default_nettype none

module adc_seq_ctrl
    import adc_seq_pkg::*;
#(
    parameter int PERIPH_N = 4,
    parameter int ADDR_W = 8
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // peripheral trigger pulses
    input wire logic [PERIPH_N-1:0] periph_trig,
    // analog converter
    output var conv_req_s conv_req,
    input wire logic conv_done,
    input wire logic [9:0] conv_result,
    // masked sequencer interrupts
    output logic [3:0] seq_irq
);

    // ==========================================
    // helpers and state
    function automatic logic [3:0] seq_cap(input logic [1:0] s);
        return (s == 2'd0) ? `CAP_SS0 : ((s == 2'd3) ? `CAP_SS3 : `CAP_MID);
    endfunction

    function automatic logic [2:0] ptr_inc(input logic [2:0] p, input logic [1:0] s);
        return ({1'b0, p} == seq_cap(s) - 4'd1) ? 3'd0 : p + 3'd1;
    endfunction

    logic [3:0] enable, raw_irq, irq_mask, overflow, underflow, pending;
    logic [15:0] trig_sel, priority_val;
    logic [2:0] avg_ctl;
    logic [31:0] step_input_select [4], step_control [4];
    logic [9:0] fifo_mem [4][8];
    logic [2:0] head [4], tail [4];
    logic [3:0] count [4];
    seq_state_e state;
    logic [1:0] cur_seq;
    logic [2:0] step;
    logic [6:0] avg_cnt;
    logic [15:0] acc;
    logic [3:0] div_cnt;

    // ==========================================
    // bus decode
    wire logic wr_go = clk_en & write & ~waitrequest;
    wire logic rd_go = clk_en & read & ~waitrequest;
    wire logic [7:0] addr8 = 8'(address);
    wire logic in_seq = (addr8 >= `SEQ_BASE) && (addr8 < `SEQ_LIMIT);
    wire logic [1:0] bus_seq = 2'(addr8[7:5] - `SEQ_BASE_IDX);
    wire logic [4:0] sub = addr8[4:0];
    wire logic [3:0] clr_irq = (wr_go && addr8 == `OFS_IRQ_CLEAR) ? writedata[3:0] : 4'h0;
    wire logic [3:0] clr_ovf = (wr_go && addr8 == `OFS_OVERFLOW) ? writedata[3:0] : 4'h0;
    wire logic [3:0] clr_unf = (wr_go && addr8 == `OFS_UNDERFLOW) ? writedata[3:0] : 4'h0;
    wire logic pop_req = rd_go && in_seq && sub == `SUB_FIFO;

    // ==========================================
    // converter-rate tick and sequencing decode
    wire logic tick = clk_en && (div_cnt == 4'(`CONV_DIV - 1));
    wire logic [4:0] nib = {step, 2'b00};
    wire logic [3:0] cur_mux = step_input_select[cur_seq][nib +: 4];
    wire logic [3:0] cur_ctl = step_control[cur_seq][nib +: 4];
    wire logic cur_last = cur_ctl[`CTL_END] || ({1'b0, step} == seq_cap(cur_seq) - 4'd1);
    wire logic [2:0] avg_shift = (avg_ctl > `AVG_MAX) ? `AVG_MAX : avg_ctl;
    wire logic [6:0] avg_last = 7'((7'd1 << avg_shift) - 7'd1);
    wire logic [15:0] acc_sum = acc + {6'h00, conv_result};
    wire logic [9:0] avg_result = 10'(acc >> avg_shift);
    wire logic done_go = clk_en && state == S_CONV && conv_req.valid && conv_done;
    wire logic abort = clk_en && state != S_IDLE && !enable[cur_seq];
    wire logic store_go = tick && state == S_STORE && enable[cur_seq];
    wire logic [3:0] push_full = (count[cur_seq] == seq_cap(cur_seq)) ? 4'hF : 4'h0;

    // ==========================================
    // triggers and arbitration
    logic [3:0] trig_evt, sw_hit, eligible, full, empty;
    logic [1:0] win;
    logic [2:0] best;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            sw_hit[i] = wr_go && addr8 == `OFS_SW_INIT && writedata[i]
                && trig_sel[i*4 +: 4] == `TRIG_SW;
            if (trig_sel[i*4 +: 4] == `TRIG_ALWAYS) begin
                trig_evt[i] = enable[i];
            end else if (trig_sel[i*4 +: 4] == `TRIG_SW) begin
                trig_evt[i] = enable[i] && sw_hit[i];
            end else if (int'(trig_sel[i*4 +: 4]) <= PERIPH_N) begin
                trig_evt[i] = enable[i] && periph_trig[int'(trig_sel[i*4 +: 4]) - 1];
            end else begin
                trig_evt[i] = 1'b0;
            end
            full[i] = count[i] == seq_cap(2'(i));
            empty[i] = count[i] == 4'd0;
        end
    end

    assign eligible = pending & enable;

    always_comb begin
        win = 2'd0;
        best = 3'd4;
        for (int i = 0; i < 4; i++) begin
            if (eligible[i] && {1'b0, priority_val[i*4 +: 2]} < best) begin
                best = {1'b0, priority_val[i*4 +: 2]};
                win = 2'(i);
            end
        end
    end

    wire logic start_go = tick && state == S_IDLE && |eligible;
    wire logic [3:0] start_mask = start_go ? (4'h1 << win) : 4'h0;
    wire logic [3:0] ie_set = (store_go && cur_ctl[`CTL_IE]) ? (4'h1 << cur_seq) : 4'h0;
    wire logic [3:0] ovf_set = (store_go ? (4'h1 << cur_seq) : 4'h0) & push_full;
    wire logic [3:0] unf_set = (pop_req && empty[bus_seq]) ? (4'h1 << bus_seq) : 4'h0;
    wire logic [3:0] push_hit = store_go ? ((4'h1 << cur_seq) & ~full) : 4'h0;
    wire logic [3:0] pop_hit = pop_req ? ((4'h1 << bus_seq) & ~empty) : 4'h0;

    // ==========================================
    // register file writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            enable <= 4'h0;
            irq_mask <= 4'h0;
            trig_sel <= 16'h0000;
            priority_val <= `PRI_RST;
            avg_ctl <= 3'h0;
            for (int i = 0; i < 4; i++) begin
                step_input_select[i] <= 32'h0000_0000;
                step_control[i] <= (i == 3) ? `CTL3_RST : 32'h0000_0000;
            end
        end else if (wr_go) begin
            if (addr8 == `OFS_ACTIVE) enable <= writedata[3:0];
            if (addr8 == `OFS_IRQ_MASK) irq_mask <= writedata[3:0];
            if (addr8 == `OFS_TRIG_SEL) trig_sel <= writedata[15:0];
            if (addr8 == `OFS_PRIORITY) priority_val <= writedata[15:0] & `PRI_MASK;
            if (addr8 == `OFS_AVG_CTL) avg_ctl <= writedata[2:0];
            if (in_seq && sub == `SUB_MUX) step_input_select[bus_seq] <= writedata;
            if (in_seq && sub == `SUB_CTL) step_control[bus_seq] <= writedata;
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            raw_irq <= 4'h0;
            overflow <= 4'h0;
            underflow <= 4'h0;
            pending <= 4'h0;
            seq_irq <= 4'h0;
            div_cnt <= 4'd0;
        end else if (clk_en) begin
            div_cnt <= tick ? 4'd0 : div_cnt + 4'd1;
            raw_irq <= (raw_irq & ~clr_irq) | ie_set;
            overflow <= (overflow & ~clr_ovf) | ovf_set;
            underflow <= (underflow & ~clr_unf) | unf_set;
            pending <= ((pending & ~start_mask) | trig_evt) & enable;
            seq_irq <= raw_irq & irq_mask;
        end
    end

    // ==========================================
    // result fifos
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                head[i] <= 3'd0;
                tail[i] <= 3'd0;
                count[i] <= 4'd0;
            end
        end else if (clk_en) begin
            for (int i = 0; i < 4; i++) begin
                if (push_hit[i]) head[i] <= ptr_inc(head[i], 2'(i));
                if (pop_hit[i]) tail[i] <= ptr_inc(tail[i], 2'(i));
                count[i] <= count[i] + 4'(push_hit[i]) - 4'(pop_hit[i]);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (store_go && !push_full[0]) begin
            fifo_mem[cur_seq][head[cur_seq]] <= avg_result;
        end
    end

    // ==========================================
    // sequencing engine
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            cur_seq <= 2'd0;
            step <= 3'd0;
            avg_cnt <= 7'd0;
            acc <= 16'h0000;
            conv_req <= '0;
        end else if (abort) begin
            state <= S_IDLE;
            conv_req.valid <= 1'b0;
        end else if (clk_en) begin
            unique case (state)
                S_IDLE: begin
                    if (start_go) begin
                        cur_seq <= win;
                        step <= 3'd0;
                        avg_cnt <= 7'd0;
                        acc <= 16'h0000;
                        state <= S_CONV;
                    end
                end
                S_CONV: begin
                    if (done_go) begin
                        conv_req.valid <= 1'b0;
                        acc <= acc_sum;
                        avg_cnt <= avg_cnt + 7'd1;
                        if (avg_cnt == avg_last) state <= S_STORE;
                    end else if (tick && !conv_req.valid) begin
                        conv_req.valid <= 1'b1;
                        conv_req.diff <= cur_ctl[`CTL_DIFF];
                        conv_req.temp <= cur_ctl[`CTL_TS];
                        conv_req.pos_input <= cur_ctl[`CTL_DIFF] ? {cur_mux[2:0], 1'b0} : cur_mux;
                        conv_req.neg_input <= cur_ctl[`CTL_DIFF] ? {cur_mux[2:0], 1'b1} : 4'h0;
                    end
                end
                S_STORE: begin
                    if (tick) begin
                        avg_cnt <= 7'd0;
                        acc <= 16'h0000;
                        state <= cur_last ? S_IDLE : S_CONV;
                        if (!cur_last) step <= step + 3'd1;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // bus answer: one wait cycle, then data and ack together
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        if (in_seq) begin
            if (sub == `SUB_MUX) rdata = step_input_select[bus_seq];
            if (sub == `SUB_CTL) rdata = step_control[bus_seq];
            if (sub == `SUB_FIFO) rdata = {22'h000000, fifo_mem[bus_seq][tail[bus_seq]]};
            if (sub == `SUB_FSTAT) begin
                rdata[2:0] = tail[bus_seq];
                rdata[`FST_HEAD +: 3] = head[bus_seq];
                rdata[`FST_EMPTY] = empty[bus_seq];
                rdata[`FST_FULL] = full[bus_seq];
            end
        end else begin
            unique case (addr8)
                `OFS_ACTIVE: rdata[3:0] = enable;
                `OFS_RAW_IRQ: rdata[3:0] = raw_irq;
                `OFS_IRQ_MASK: rdata[3:0] = irq_mask;
                `OFS_IRQ_CLEAR: rdata[3:0] = raw_irq & irq_mask;
                `OFS_OVERFLOW: rdata[3:0] = overflow;
                `OFS_TRIG_SEL: rdata[15:0] = trig_sel;
                `OFS_UNDERFLOW: rdata[3:0] = underflow;
                `OFS_PRIORITY: rdata[15:0] = priority_val;
                `OFS_AVG_CTL: rdata[2:0] = avg_ctl;
                default: rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end else if (clk_en) begin
            waitrequest <= !(waitrequest && (read || write));
            if (waitrequest && read) readdata <= rdata;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence seq_store_last;
        store_go && cur_last && !abort;
    endsequence

    sequence seq_idle_after;
        state == S_IDLE;
    endsequence

    chk_req_held: assert property (
        clk_en && state == S_CONV && conv_req.valid && !conv_done && !abort
        |=> conv_req.valid)
        else $error("request dropped before completion");

    chk_disable_stop: assert property (abort |=> state == S_IDLE && !conv_req.valid)
        else $error("sequence continued while disabled");

    chk_end_stop: assert property (seq_store_last |=> seq_idle_after)
        else $error("sequence ran past its end step");

    chk_irq_masked: assert property (
        clk_en |=> seq_irq == ($past(raw_irq) & $past(irq_mask)))
        else $error("interrupt output not raw status gated by mask");

    chk_clear_one: assert property (clr_irq[0] && !ie_set[0] |=> !raw_irq[0])
        else $error("interrupt bit not cleared by writing one");

    chk_step_irq: assert property (
        ie_set != 4'h0 |=> (raw_irq & $past(ie_set)) == $past(ie_set))
        else $error("step interrupt not raised");

    chk_overflow_set: assert property (
        ovf_set[3] && !pop_req |=> overflow[3] && count[3] == `CAP_SS3)
        else $error("overflow not recorded");

    chk_underflow_set: assert property (
        unf_set[0] && !store_go |=> underflow[0] && count[0] == 4'd0)
        else $error("underflow not recorded");

    chk_fifo_depth: assert property (
        count[0] <= `CAP_SS0 && count[1] <= `CAP_MID
        && count[2] <= `CAP_MID && count[3] <= `CAP_SS3)
        else $error("fifo count above capacity");

    chk_pop_advance: assert property (
        pop_req && bus_seq == 2'd0 && !empty[0] |=> tail[0] == ptr_inc($past(tail[0]), 2'd0))
        else $error("read did not remove oldest entry");

    chk_priority_reset: assert property ($rose(rst_n) |-> priority_val == `PRI_RST)
        else $error("priority reset value wrong");

endmodule

`default_nettype wire

// file: testbench/conv_model.sv
// behavioural converter: answers each held request after a short or long delay
`timescale 1ns/1ns
`default_nettype none

module conv_model
    import adc_seq_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // request side
    input wire conv_req_s conv_req,
    input wire logic slow,
    // answer side
    output logic conv_done,
    output logic [9:0] conv_result
);
    int wait_cnt;

    // ==========================================
    // answer one request at a time, code made from the selected inputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= 0;
            conv_done <= 1'b0;
            conv_result <= 10'h2AA;
        end else if (conv_done) begin
            // result line no longer holds the code once the strobe is gone
            conv_done <= 1'b0;
            conv_result <= ~conv_result;
            wait_cnt <= 0;
        end else if (conv_req.valid) begin
            if (wait_cnt == (slow ? 20 : 2)) begin
                conv_done <= 1'b1;
                conv_result <= {conv_req.diff, conv_req.temp, conv_req.pos_input,
                                conv_req.neg_input};
                wait_cnt <= 0;
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end else begin
            wait_cnt <= 0;
        end
    end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the sample sequencer control
`timescale 1ns/1ns
`include "adc_seq_regs.svh"
`default_nettype none

module tb_top;
    import adc_seq_pkg::*;
    logic mclk, rst_n, clk_en, read, write, waitrequest, conv_done, slow;
    logic [7:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [3:0] periph_trig, seq_irq;
    logic [9:0] conv_result;
    conv_req_s conv_req;
    int n_mismatch, comparisons, done_cnt;

    adc_seq_ctrl dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .periph_trig(periph_trig), .conv_req(conv_req),
        .conv_done(conv_done), .conv_result(conv_result), .seq_irq(seq_irq));
    conv_model partner (.mclk(mclk), .rst_n(rst_n), .conv_req(conv_req), .slow(slow),
        .conv_done(conv_done), .conv_result(conv_result));

    // ==========================================
    // clock, conversion counter, watchdog
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (conv_done === 1'b1) done_cnt++;
    end
    initial begin
        #(8 * 40000);
        n_mismatch++;
        end_of_test();
    end

    // ==========================================
    // shared tasks
    task automatic end_of_test();
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // no wait limit of its own: a hung slave is ended by the watchdog
    task automatic bus(input logic rw, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        address <= a;
        writedata <= d;
        write <= rw;
        read <= !rw;
        do begin
            @(posedge mclk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    function automatic logic [7:0] sa(input int n, input logic [4:0] sub);
        return `SEQ_BASE + 8'(n * 32) + 8'(sub);
    endfunction
    // conversion count reached, then one store tick plus margin
    task automatic wait_done(input int n);
        int k;
        k = 0;
        while (done_cnt < n && k < 3000) begin
            @(posedge mclk);
            k++;
        end
        if (k >= 3000) check(32'(done_cnt), 32'(n));
        repeat (16) @(posedge mclk);
    endtask
    task automatic pulse_trig();
        @(posedge mclk);
        periph_trig <= 4'h1;
        @(posedge mclk);
        periph_trig <= 4'h0;
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        rchk(`OFS_PRIORITY, 32'h3210);
        rchk(sa(3, `SUB_CTL), 32'h2);
        rchk(sa(0, `SUB_FSTAT), 32'h100);
        rchk(`OFS_AVG_CTL, 32'h0);
        wr(8'hFC, 32'hFFFF_FFFF);
        rchk(8'hFC, 32'h0);
    endtask
    task automatic t_seq0();
        // end bit on step 2 of a capacity-8 sequencer, step 3 must never run
        wr(sa(0, `SUB_MUX), 32'h5321);
        wr(sa(0, `SUB_CTL), 32'h2E50);
        wr(`OFS_TRIG_SEL, 32'h0);
        wr(`OFS_ACTIVE, 32'h1);
        done_cnt = 0;
        wr(`OFS_SW_INIT, 32'h1);
        wait_done(3);
        repeat (100) @(posedge mclk);
        check(32'(done_cnt), 32'd3);
        rchk(`OFS_RAW_IRQ, 32'h1);
        rchk(`OFS_IRQ_CLEAR, 32'h0);
        check({28'h0, seq_irq}, 32'h0);
        rchk(sa(0, `SUB_FIFO), 32'h010);
        rchk(sa(0, `SUB_FIFO), 32'h245);
        rchk(sa(0, `SUB_FIFO), 32'h130);
        rchk(sa(0, `SUB_FSTAT), 32'h133);
        bus(1'b0, sa(0, `SUB_FIFO), 32'h0);
        rchk(`OFS_UNDERFLOW, 32'h1);
        wr(`OFS_UNDERFLOW, 32'h1);
        rchk(`OFS_UNDERFLOW, 32'h0);
        wr(`OFS_IRQ_MASK, 32'h1);
        rchk(`OFS_IRQ_CLEAR, 32'h1);
        check({28'h0, seq_irq}, 32'h1);
        wr(`OFS_IRQ_CLEAR, 32'h0);
        rchk(`OFS_RAW_IRQ, 32'h1);
        wr(`OFS_IRQ_CLEAR, 32'h1);
        rchk(`OFS_RAW_IRQ, 32'h0);
        check({28'h0, seq_irq}, 32'h0);
        wr(`OFS_ACTIVE, 32'h0);
    endtask
    task automatic t_overflow();
        wr(sa(3, `SUB_MUX), 32'h1);
        wr(`OFS_TRIG_SEL, 32'hF000);
        done_cnt = 0;
        wr(`OFS_ACTIVE, 32'h8);
        wait_done(3);
        wr(`OFS_ACTIVE, 32'h0);
        bus(1'b0, sa(3, `SUB_FSTAT), 32'h0);
        check(32'(rd[`FST_FULL]), 32'h1);
        rchk(`OFS_OVERFLOW, 32'h8);
        rchk(sa(3, `SUB_FIFO), 32'h010);
        bus(1'b0, sa(3, `SUB_FSTAT), 32'h0);
        check(32'(rd[`FST_EMPTY]), 32'h1);
        wr(`OFS_OVERFLOW, 32'h8);
        rchk(`OFS_OVERFLOW, 32'h0);
    endtask
    task automatic t_priority();
        int k;
        // distinct priorities, sequencer two now first
        wr(`OFS_PRIORITY, 32'h3021);
        wr(sa(1, `SUB_MUX), 32'h1);
        wr(sa(1, `SUB_CTL), 32'h2);
        wr(sa(2, `SUB_MUX), 32'h2);
        wr(sa(2, `SUB_CTL), 32'h2);
        wr(`OFS_TRIG_SEL, 32'h0);
        wr(`OFS_ACTIVE, 32'h6);
        done_cnt = 0;
        wr(`OFS_SW_INIT, 32'h6);
        k = 0;
        while (conv_req.valid !== 1'b1 && k < 200) begin
            @(posedge mclk);
            k++;
        end
        check(32'(conv_req.pos_input), 32'h2);
        wait_done(2);
        rchk(sa(2, `SUB_FIFO), 32'h020);
        rchk(sa(1, `SUB_FIFO), 32'h010);
        wr(`OFS_ACTIVE, 32'h0);
    endtask
    task automatic t_periph();
        wr(sa(1, `SUB_MUX), 32'h4);
        wr(`OFS_TRIG_SEL, 32'h10);
        done_cnt = 0;
        pulse_trig();
        repeat (100) @(posedge mclk);
        check(32'(done_cnt), 32'h0);
        wr(`OFS_ACTIVE, 32'h2);
        // a trigger seen while the clock enable is low must be lost
        clk_en <= 1'b0;
        pulse_trig();
        repeat (20) @(posedge mclk);
        check(32'(done_cnt), 32'h0);
        clk_en <= 1'b1;
        pulse_trig();
        wait_done(1);
        rchk(sa(1, `SUB_FIFO), 32'h040);
        wr(`OFS_ACTIVE, 32'h0);
    endtask
    task automatic t_average();
        slow <= 1'b1;
        wr(`OFS_AVG_CTL, 32'h2);
        rchk(`OFS_AVG_CTL, 32'h2);
        wr(`OFS_TRIG_SEL, 32'h0);
        wr(`OFS_ACTIVE, 32'h8);
        done_cnt = 0;
        wr(`OFS_SW_INIT, 32'h8);
        wait_done(4);
        repeat (200) @(posedge mclk);
        check(32'(done_cnt), 32'd4);
        rchk(sa(3, `SUB_FIFO), 32'h010);
        wr(`OFS_ACTIVE, 32'h0);
        slow <= 1'b0;
    endtask

    // ==========================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0;
        periph_trig = 4'h0;
        slow = 1'b0;
        n_mismatch = 0;
        comparisons = 0;
        done_cnt = 0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_seq0();
        t_overflow();
        t_priority();
        t_periph();
        t_average();
        end_of_test();
    end
endmodule
`default_nettype wire
